// ### dv/sbi_bus_partner.sv
// far-side bus master model: drives clock and data only through open-drain pulls
module sbi_bus_partner (
  input  wire logic scl_wire_in,
  output logic      scl_pull_out,
  output logic      sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = 80;
  initial
  begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  // release clock, honour a stretch up to a bound, then hold the high half
  task automatic scl_high();
    scl_pull_out = 1'b0;
    for (int i = 0; i < 400 && scl_wire_in !== 1'b1; i++)
      #10;
    #HALF_NS;
  endtask
  // data released first so a low clock rise never looks like a stop
  task automatic send_start();
    #1; // step off the clock edge so pins never race the sampling flops
    sda_pull_out = 1'b0;
    #HALF_NS;
    scl_high();
    sda_pull_out = 1'b1;
    #HALF_NS;
    scl_pull_out = 1'b1;
    #HALF_NS;
  endtask
  task automatic send_bit(input logic b);
    #1;
    sda_pull_out = ~b;
    #HALF_NS;
    scl_high();
    scl_pull_out = 1'b1;
    #HALF_NS;
  endtask
  task automatic send_stop();
    #1;
    sda_pull_out = 1'b1;
    #HALF_NS;
    scl_high();
    sda_pull_out = 1'b0;
    #HALF_NS;
  endtask
endmodule

// ### dv/sbi_checker.sv
// port checker for the single-bit serial bus interface
module sbi_checker (
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       timer_run_bit_in,
  input wire logic       global_irq_enable_in,
  input wire logic [7:0] second_irq_enable_reg_in,
  input wire logic       timer_prio_high_bit_in,
  input wire logic       timer_prio_low_bit_in,
  input wire logic       bus_irq_out,
  input wire logic       timer_irq_out,
  input wire logic [1:0] timer_prio_out,
  input wire logic       scl_in,
  input wire logic       scl_oe_out,
  input wire logic       sda_oe_out
);
  localparam int unsigned SPAN_MIN = 1019 * 6;
  logic [15:0] since_r;
  logic        scl_q_r;
  ////////////////////////////////////////////////////////////////////////////////
  // clocks since last raw clock-line change; saturates so long idle cannot wrap
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      since_r <= 16'h0000;
      scl_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_in;
      since_r <= (scl_in != scl_q_r) ? 16'h0000 : since_r + {15'h0000, ~&since_r};
    end
  ////////////////////////////////////////////////////////////////////////////////
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_rd_data;
    sfr_rd_in && sfr_addr_in == sbi_pkg::ADDR_DATA;
  endsequence
  sequence s_rd_ctrl;
    sfr_rd_in && sfr_addr_in == sbi_pkg::ADDR_CTRL;
  endsequence
  property p_data_low_zero;
    s_rd_data |=> sfr_rdata_out[6:0] == 7'h00;
  endproperty
  a_data_low_zero: assert property (p_data_low_zero) else $error("data read low bits set");
  property p_attn;
    s_rd_ctrl |=> sfr_rdata_out[6] == |sfr_rdata_out[5:2];
  endproperty
  a_attn: assert property (p_attn) else $error("attention not the or of the flags");
  property p_rdata_hold;
    !(sfr_rd_in && (sfr_addr_in == sbi_pkg::ADDR_CTRL || sfr_addr_in == sbi_pkg::ADDR_DATA))
      |=> $stable(sfr_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_bus_irq_gate;
    !(global_irq_enable_in && second_irq_enable_reg_in[0]) |=> !bus_irq_out;
  endproperty
  a_bus_irq_gate: assert property (p_bus_irq_gate) else $error("bus irq while disabled");
  property p_tmr_gate_en;
    !second_irq_enable_reg_in[7] |=> !timer_irq_out;
  endproperty
  a_tmr_gate_en: assert property (p_tmr_gate_en) else $error("timer irq while disabled");
  property p_tmr_gate_run;
    !timer_run_bit_in |=> !timer_irq_out;
  endproperty
  a_tmr_gate_run: assert property (p_tmr_gate_run) else $error("timeout with timer stopped");
  property p_tmr_pulse;
    timer_irq_out |=> !timer_irq_out;
  endproperty
  a_tmr_pulse: assert property (p_tmr_pulse) else $error("timer irq longer than one cycle");
  property p_tmr_release;
    timer_irq_out |-> !scl_oe_out && !sda_oe_out;
  endproperty
  a_tmr_release: assert property (p_tmr_release) else $error("bus still held at timeout");
  property p_tmr_span;
    timer_irq_out |-> since_r >= SPAN_MIN;
  endproperty
  a_tmr_span: assert property (p_tmr_span) else $error("timeout came too early");
  property p_prio;
    $past(reset_n_in) |->
      timer_prio_out == {$past(timer_prio_high_bit_in), $past(timer_prio_low_bit_in)};
  endproperty
  a_prio: assert property (p_prio) else $error("timer priority does not follow inputs");
endmodule

bind sbi_top sbi_checker u_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .timer_run_bit_in(timer_run_bit_in),
  .global_irq_enable_in(global_irq_enable_in),
  .second_irq_enable_reg_in(second_irq_enable_reg_in),
  .timer_prio_high_bit_in(timer_prio_high_bit_in), .timer_prio_low_bit_in(timer_prio_low_bit_in),
  .bus_irq_out(bus_irq_out), .timer_irq_out(timer_irq_out), .timer_prio_out(timer_prio_out),
  .scl_in(scl_in), .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out)
);

// ### dv/test_sbi_top.sv
// self-checking bench for the single-bit serial bus interface
module test_sbi_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C = sbi_pkg::ADDR_CTRL;
  localparam logic [7:0] D = sbi_pkg::ADDR_DATA;
  logic       clk_sys_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ie = 8'h00, rv, rdata;
  logic       wr = 1'b0, rd = 1'b0, run = 1'b0, gie = 1'b0, ph = 1'b0, pl = 1'b0;
  logic [1:0] psel = 2'h0, prio;
  logic       bus_irq, tmr_irq, scl_oe, sda_oe, p_scl, p_sda, scl_w, sda_w;
  logic       mreq = 1'b0, scl_o, sda_o;
  int         err_total = 0, samples_checked = 0, cyc = 0, n;
  // open-drain wires with pull-ups
  assign scl_w = ~(scl_oe | p_scl);
  assign sda_w = ~(sda_oe | p_sda);
  sbi_bus_partner p (.scl_wire_in(scl_w), .scl_pull_out(p_scl), .sda_pull_out(p_sda));
  sbi_top dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer_run_bit_in(run),
    .prescale_sel_in(psel), .master_request_in(mreq), .global_irq_enable_in(gie),
    .second_irq_enable_reg_in(ie), .timer_prio_high_bit_in(ph), .timer_prio_low_bit_in(pl),
    .bus_irq_out(bus_irq), .timer_irq_out(tmr_irq), .timer_prio_out(prio),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe)
  );
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle strobes, as the register port expects
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // control read compared under a mask, received_bit excluded where it is not defined
  task automatic rc(input string name, input logic [7:0] e, input logic [7:0] m = 8'hff);
    rd_reg(C, rv);
    chk(name, rv & m, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, well above the two timeout waits
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rc("ctrl_reset", sbi_pkg::CTRL_RESET);
    gie <= 1'b1;
    ie <= 8'h01;
    p.send_start();
    rc("ctrl_start", 8'hc9);
    chk("bus_irq_on", {7'h00, bus_irq}, 8'h01);
    wr_reg(C, 8'h08);
    ie <= 8'h00;
    rc("ctrl_clr_start", 8'h81);
    p.send_bit(1'b0);
    rc("ctrl_bit0", 8'h61);
    rc("ctrl_bit0_again", 8'h61);
    chk("bus_irq_off", {7'h00, bus_irq}, 8'h00);
    chk("stretch_on", {7'h00, scl_oe}, 8'h01);
    rd_reg(D, rv);
    chk("data_bit0", rv, 8'h00);
    rc("ctrl_after_data", 8'h01);
    repeat (4) @(posedge clk_sys_in);
    chk("stretch_off", {7'h00, scl_oe}, 8'h00);
    p.send_bit(1'b1);
    rd_reg(D, rv);
    chk("data_bit1", rv, 8'h80);
    p.send_bit(1'b1);
    wr_reg(D, 8'h00);
    rc("ctrl_tx_clr", 8'h81);
    p.send_bit(1'b1);
    rc("ctrl_tx_low", 8'h61);
    wr_reg(D, 8'h80);
    p.send_bit(1'b0);
    rc("ctrl_arb_lost", 8'h71);
    wr_reg(C, 8'hb0);
    rc("ctrl_arb_clr", 8'h01);
    rd_reg(8'hda, rv);
    chk("unmapped_hold", rv, 8'h01);
    wr_reg(D, 8'h00);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("tx_drive_low", {7'h00, sda_oe}, 8'h01);
    wr_reg(C, 8'h80);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("tx_cleared", {7'h00, sda_oe}, 8'h00);
    wr_reg(C, 8'h40);
    p.send_bit(1'b1);
    rc("ctrl_idle", 8'h01, 8'h7f);
    chk("idle_no_stretch", {7'h00, scl_oe}, 8'h00);
    p.send_start();
    rc("ctrl_rs_start", 8'h49, 8'h7f);
    wr_reg(C, 8'h08);
    p.send_bit(1'b1);
    rc("ctrl_readdressed", 8'he1);
    wr_reg(C, 8'h20);
    p.send_stop();
    rc("ctrl_stop", 8'h65, 8'h7f);
    wr_reg(C, 8'h24);
    rc("ctrl_stop_clr", 8'h01, 8'h7f);
    // master: start, one clock, then held low waiting on data ready
    mreq <= 1'b1;
    repeat (30) @(posedge clk_sys_in);
    rc("master_clocking", 8'heb);
    chk("master_hold_low", {7'h00, scl_oe}, 8'h01);
    chk("pins_drive_low", {6'h00, scl_o, sda_o}, 8'h00);
    mreq <= 1'b0;
    wr_reg(C, 8'h21);
    repeat (20) @(posedge clk_sys_in);
    rc("master_stop", 8'h6d);
    wr_reg(C, 8'h2c);
    rc("master_stop_clr", 8'h01, 8'h7f);
    for (int i = 0; i < 4; i++)
    begin
      {ph, pl} <= i[1:0];
      repeat (3) @(posedge clk_sys_in);
      chk("prio", {6'h00, prio}, {6'h00, i[1:0]});
    end
    psel <= 2'h3;
    ie <= 8'h81;
    p.send_start();
    n = 0;
    repeat (6300) @(posedge clk_sys_in) n += int'(tmr_irq === 1'b1);
    chk("no_run_no_timeout", n[7:0], 8'h00);
    run <= 1'b1;
    p.send_bit(1'b0);
    n = 0;
    while (tmr_irq !== 1'b1 && n < 7000)
    begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk("timeout_span", {7'h00, n >= 6100 && n <= 6124}, 8'h01);
    chk("timeout_release", {7'h00, scl_oe}, 8'h00);
    rc("ctrl_timeout", 8'h00, 8'h7e);
    complete_run();
  end
endmodule

// ### logic/sbi_pkg.sv
// constants for the single-bit serial bus interface with bus-supervision timer
//
// Operation
// R1: every rising clock-line edge captures the data line into the received bit, bit 7.
// R2: bit data read returns received bit over seven zeros and clears data ready.
// R3: attention reads 1 whenever data ready, arbitration lost, start or stop flag is set.
// R4: data ready sets on clock rise except idle slave; cleared by clear bit or data access.
// R5: clock line is held low while data ready stays set.
// R6: bit data write loads next transmit bit, clears data ready, enters transmit active.
// R7: writing 1 to control bit 7 clears transmit active.
// R8: idle slave write makes hardware ignore the bus until the next start.
// R9: control writes generate a repeated start or a stop on the bus.
// R10: bus interrupt when global and bus enables set and attention is set.
// R11: software enables the bus interrupt only for idle waits, else polls attention.
// R12: low three timer bits time minimum high, low, setup and bus-free spacing.
// R13: timer stretches the clock low period to its minimum when software is fast.
// R14: timer preload picked from four values by two prescale bits.
// R15: ten-bit timer counts maximum clock change time, cleared by clock-line transitions.
// R16: frame runs start to stop; timer idle when reset or stop is newer. Here the timer keeps counting and only its carry is masked.
// R17: running timer carries out after 1020 to 1023 machine cycles without change.
// R18: carry-out resets the interface, releases the clock line, raises timer interrupt.
// R19: timer runs and resets the interface only while timer-run bit is set.
// R20: timer interrupt enable is bit 7, bus interrupt enable bit 0.
// R21: timer priority comes from a high-byte bit and a low-byte bit.
// R22: transmitting a 1 but sampling 0 sets arbitration lost and releases data line.
// R23: start and stop flags set at master or non-idle slave, cleared by own bits.
package sbi_pkg;

  // register addresses and reset values
  localparam logic [7:0] ADDR_CTRL      = 8'hd8;
  localparam logic [7:0] ADDR_DATA      = 8'hd9;
  localparam logic [7:0] CTRL_RESET     = 8'h81;

  // control/status write field positions
  localparam int unsigned WB_CLR_XACT   = 7;
  localparam int unsigned WB_IDLE       = 6;
  localparam int unsigned WB_CLR_DATA_READY_FLAG   = 5;
  localparam int unsigned WB_CLR_ARL    = 4;
  localparam int unsigned WB_CLR_STR    = 3;
  localparam int unsigned WB_CLR_STP    = 2;
  localparam int unsigned WB_SEND_RS    = 1;
  localparam int unsigned WB_SEND_STOP  = 0;
  localparam int unsigned DB_BIT        = 7;

  // interrupt enable field positions
  localparam int unsigned IEB_TIMER     = 7;
  localparam int unsigned IEB_BUS       = 0;

  // machine cycle timing: the timer advances once per machine cycle
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned MC_NS         = 60;
  localparam int unsigned MC_CLKS       = (MC_NS + CLK_NS - 1) / CLK_NS;

  // supervision timer geometry and preloads per prescale selection
  localparam int unsigned TMR_W         = 10;
  localparam logic [9:0]  TMR_PRELOAD0  = 10'h001;
  localparam logic [9:0]  TMR_PRELOAD1  = 10'h002;
  localparam logic [9:0]  TMR_PRELOAD2  = 10'h003;
  localparam logic [9:0]  TMR_PRELOAD3  = 10'h004;
  localparam logic [9:0]  TMR_LAST      = 10'h3ff;
  localparam logic [2:0]  MIN_LAST      = 3'h7;

  typedef enum logic [3:0] {
    SBI_M_IDLE, SBI_M_START, SBI_M_LOW, SBI_M_RISE, SBI_M_HIGH,
    SBI_M_RS_SDA, SBI_M_RS_RISE, SBI_M_STOP_SDA, SBI_M_STOP_RISE, SBI_M_FREE
  } sbi_mstate_t;

endpackage

// ### logic/sbi_top.sv
// single-bit serial bus interface: bit engine, master sequencer, supervision timer
module sbi_top (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  // special function register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // configuration and interrupt control bits
  input  wire logic       timer_run_bit_in,
  input  wire logic [1:0] prescale_sel_in,
  input  wire logic       master_request_in,
  input  wire logic       global_irq_enable_in,
  input  wire logic [7:0] second_irq_enable_reg_in,
  input  wire logic       timer_prio_high_bit_in,
  input  wire logic       timer_prio_low_bit_in,
  output logic            bus_irq_out,
  output logic            timer_irq_out,
  output logic      [1:0] timer_prio_out,
  // open-drain bus pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus event detection

  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;

  // bus idles high, so the chain resets high to avoid a false event
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end
    else
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end

  // one-clock strobes taken from the synchronised pair and its delay flop
  wire scl_rise  = scl_s2_r & ~scl_d_r;
  wire scl_chg   = scl_s2_r ^ scl_d_r;
  wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  // address compare and per-bit write strobes; unmapped addresses do nothing
  wire ctrl_sel = (sfr_addr_in == sbi_pkg::ADDR_CTRL);
  wire data_sel = (sfr_addr_in == sbi_pkg::ADDR_DATA);
  wire ctrl_wr  = sfr_wr_in & ctrl_sel;
  wire data_wr  = sfr_wr_in & data_sel;
  wire data_rd  = sfr_rd_in & data_sel;
  wire w_cxa    = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_CLR_XACT];
  wire w_idle   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_IDLE];
  wire w_cdr    = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_CLR_DATA_READY_FLAG];
  wire w_clear_arbitration_lost   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_CLR_ARL];
  wire w_clear_start_seen   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_CLR_STR];
  wire w_clear_stop_seen   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_CLR_STP];
  wire w_send_repeated_start   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_SEND_RS];
  wire w_send_stop   = ctrl_wr & sfr_wdata_in[sbi_pkg::WB_SEND_STOP];

  ////////////////////////////////////////////////////////////////////////////
  // supervision timer

  logic [2:0]             mc_cnt_r;
  logic [sbi_pkg::TMR_W-1:0] tmr_r;
  logic                   min_done_r;
  logic                   frame_r;
  logic                   m_step;
  logic [9:0]             tmr_preload;

  // preload picks the carry point within the 1020..1023 window
  always_comb
  begin
    case (prescale_sel_in) // R14
      2'h0:    tmr_preload = sbi_pkg::TMR_PRELOAD0;
      2'h1:    tmr_preload = sbi_pkg::TMR_PRELOAD1;
      2'h2:    tmr_preload = sbi_pkg::TMR_PRELOAD2;
      default: tmr_preload = sbi_pkg::TMR_PRELOAD3;
    endcase
  end

  // machine-cycle prescaler: the timer only counts up on mc_tick
  wire mc_tick     = (mc_cnt_r == 3'(sbi_pkg::MC_CLKS - 1));
  wire tmr_restart = scl_chg | m_step; // R15
  wire tmr_run     = timer_run_bit_in; // R19
  // timer keeps counting outside a frame but its carry is masked there; only a clock-line change
  // vetoes the carry, since the sequencer's own step depends on timeout
  wire timeout     = tmr_run & frame_r & mc_tick & ~scl_chg
                   & (tmr_r == sbi_pkg::TMR_LAST); // R16 R17
  // with the timer stopped no minimum spacing is enforced
  wire min_ok      = min_done_r | ~tmr_run; // R12 R13
  wire min_carry   = mc_tick & (tmr_r[2:0] == sbi_pkg::MIN_LAST);

  // a restart reloads the preload so every span is timed afresh
  wire [2:0] mc_cnt_nxt = mc_tick ? 3'h0 : mc_cnt_r + 3'h1;
  wire [9:0] tmr_nxt    = (!tmr_run || tmr_restart) ? tmr_preload
                        : mc_tick ? tmr_r + 10'h001 : tmr_r; // R15
  wire       min_nxt    = tmr_restart ? 1'b0 : (min_done_r | min_carry); // R12

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mc_cnt_r   <= 3'h0;
      tmr_r      <= sbi_pkg::TMR_PRELOAD0;
      min_done_r <= 1'b0;
    end
    else
    begin
      mc_cnt_r   <= mc_cnt_nxt;
      tmr_r      <= tmr_nxt;
      min_done_r <= min_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master sequencer

  sbi_pkg::sbi_mstate_t m_state_r, m_state_nxt;
  logic send_repeated_start_pend_r, send_stop_pend_r;
  logic data_ready_flag_r, arl_r;

  // next state; every phase except the clock rise waits for its minimum time first
  always_comb
  begin
    m_state_nxt = m_state_r;
    case (m_state_r)
      sbi_pkg::SBI_M_IDLE:
        if (master_request_in && !frame_r && min_ok)
          m_state_nxt = sbi_pkg::SBI_M_START;
      sbi_pkg::SBI_M_START:
        if (min_ok)
          m_state_nxt = sbi_pkg::SBI_M_LOW;
      sbi_pkg::SBI_M_LOW:
        if (min_ok && send_stop_pend_r) // R9
          m_state_nxt = sbi_pkg::SBI_M_STOP_SDA;
        else if (min_ok && send_repeated_start_pend_r) // R9
          m_state_nxt = sbi_pkg::SBI_M_RS_SDA;
        else if (min_ok && !data_ready_flag_r) // R5 R13
          m_state_nxt = sbi_pkg::SBI_M_RISE;
      sbi_pkg::SBI_M_RISE:
        if (scl_s2_r)
          m_state_nxt = sbi_pkg::SBI_M_HIGH;
      sbi_pkg::SBI_M_HIGH:
        if (min_ok) // R12
          m_state_nxt = sbi_pkg::SBI_M_LOW;
      sbi_pkg::SBI_M_RS_SDA:
        if (min_ok)
          m_state_nxt = sbi_pkg::SBI_M_RS_RISE;
      sbi_pkg::SBI_M_RS_RISE:
        if (scl_s2_r && min_ok) // R12
          m_state_nxt = sbi_pkg::SBI_M_START;
      sbi_pkg::SBI_M_STOP_SDA:
        if (min_ok)
          m_state_nxt = sbi_pkg::SBI_M_STOP_RISE;
      sbi_pkg::SBI_M_STOP_RISE:
        if (scl_s2_r && min_ok) // R12
          m_state_nxt = sbi_pkg::SBI_M_FREE;
      sbi_pkg::SBI_M_FREE:
        if (min_ok) // R12
          m_state_nxt = sbi_pkg::SBI_M_IDLE;
      default:
        m_state_nxt = sbi_pkg::SBI_M_IDLE;
    endcase
    // losing arbitration or a bus hang drops mastership at once
    if (timeout || arl_r) // R18 R22
      m_state_nxt = sbi_pkg::SBI_M_IDLE;
  end

  // any state change restarts the spacing count for the next phase
  assign m_step = (m_state_nxt != m_state_r);

  // pin decode per state; the master only ever pulls a line low
  wire m_scl_low = (m_state_r == sbi_pkg::SBI_M_LOW)
                 | (m_state_r == sbi_pkg::SBI_M_RS_SDA)
                 | (m_state_r == sbi_pkg::SBI_M_STOP_SDA);
  wire m_sda_ctl = (m_state_r == sbi_pkg::SBI_M_START)
                 | (m_state_r == sbi_pkg::SBI_M_RS_SDA)
                 | (m_state_r == sbi_pkg::SBI_M_RS_RISE)
                 | (m_state_r == sbi_pkg::SBI_M_STOP_SDA)
                 | (m_state_r == sbi_pkg::SBI_M_STOP_RISE)
                 | (m_state_r == sbi_pkg::SBI_M_FREE);
  wire m_sda_low = (m_state_r == sbi_pkg::SBI_M_START)
                 | (m_state_r == sbi_pkg::SBI_M_STOP_SDA)
                 | (m_state_r == sbi_pkg::SBI_M_STOP_RISE);
  wire is_master = (m_state_r != sbi_pkg::SBI_M_IDLE);
  wire leave_low = (m_state_r == sbi_pkg::SBI_M_LOW) & m_step;

  ////////////////////////////////////////////////////////////////////////////
  // bit engine flags

  logic xact_r, tx_bit_r, received_bit_r, idle_r, str_r, stp_r;

  // an idle slave hears only starts; a master always hears the bus
  wire listen    = ~idle_r | is_master;
  wire arl_event = scl_rise & xact_r & tx_bit_r & ~sda_s2_r; // R22
  wire attention = data_ready_flag_r | arl_r | str_r | stp_r; // R3

  // a hardware set wins over a same-cycle software clear
  wire data_ready_flag_nxt  = ~timeout & ((scl_rise & listen)
                 | (data_ready_flag_r & ~w_cdr & ~data_rd & ~data_wr)); // R4 R6 R2
  wire arl_nxt   = ~timeout & (arl_event | (arl_r & ~w_clear_arbitration_lost)); // R22
  // a start always counts: it is the very event that wakes an idle slave
  wire str_nxt   = ~timeout & (start_det | (str_r & ~w_clear_start_seen)); // R23 R8
  wire stp_nxt   = ~timeout & ((stop_det & listen) | (stp_r & ~w_clear_stop_seen)); // R23
  wire xact_nxt  = ~timeout & ~arl_event
                 & (data_wr | (xact_r & ~w_cxa)); // R6 R7 R22
  wire idle_nxt  = ~start_det & ~timeout
                 & ((w_idle & ~is_master) | idle_r); // R8
  // frame spans start to stop; a hang ends it as well
  wire frame_nxt = start_det | (frame_r & ~stop_det & ~timeout); // R16
  wire send_repeated_start_nxt  = ~timeout & is_master & (w_send_repeated_start | (send_repeated_start_pend_r & ~leave_low));
  wire send_stop_nxt  = ~timeout & is_master & (w_send_stop | (send_stop_pend_r & ~leave_low));

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      m_state_r   <= sbi_pkg::SBI_M_IDLE;
      {data_ready_flag_r, arl_r, str_r, stp_r, xact_r} <= 5'h00;
      {idle_r, frame_r, send_repeated_start_pend_r, send_stop_pend_r} <= 4'h0;
      tx_bit_r    <= 1'b1;
      received_bit_r      <= sbi_pkg::CTRL_RESET[7];
    end
    else
    begin
      m_state_r   <= m_state_nxt;
      data_ready_flag_r      <= data_ready_flag_nxt;
      arl_r       <= arl_nxt;
      str_r       <= str_nxt;
      stp_r       <= stp_nxt;
      xact_r      <= xact_nxt;
      idle_r      <= idle_nxt;
      frame_r     <= frame_nxt;
      send_repeated_start_pend_r <= send_repeated_start_nxt;
      send_stop_pend_r <= send_stop_nxt;
      if (data_wr)
        tx_bit_r  <= sfr_wdata_in[sbi_pkg::DB_BIT]; // R6
      if (scl_rise)
        received_bit_r    <= sda_s2_r; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, read data and interrupt outputs

  // slave stretch only starts once another master has pulled the clock low
  wire scl_oe_nxt = ~timeout & (m_scl_low | (data_ready_flag_r & ~scl_s2_r)); // R5 R18
  wire sda_oe_nxt = ~timeout & (m_sda_ctl ? m_sda_low
                  : (xact_r & ~tx_bit_r & ~arl_event)); // R6 R22
  // read mux: a control read leaves data ready alone, only a data read clears it
  wire [7:0] ctrl_rd = {received_bit_r, attention, data_ready_flag_r, arl_r, str_r, stp_r, is_master,
                        sbi_pkg::CTRL_RESET[0]}; // R1 R3
  wire [7:0] data_rd_val = {received_bit_r, 7'h00}; // R2
  wire [7:0] rdata_nxt = (sfr_rd_in && ctrl_sel) ? ctrl_rd
                       : (sfr_rd_in && data_sel) ? data_rd_val
                       : sfr_rdata_out;
  // the bus request is a level, the timer request a one-cycle pulse, into the core's own interrupt logic
  wire bus_irq_nxt   = global_irq_enable_in & attention
                     & second_irq_enable_reg_in[sbi_pkg::IEB_BUS]; // R10 R20
  wire timer_irq_nxt = timeout & second_irq_enable_reg_in[sbi_pkg::IEB_TIMER]; // R18 R20

  // every output is registered, which keeps glitches off the bus pins
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sfr_rdata_out  <= 8'h00;
      {scl_out, sda_out} <= 2'h0;
      {scl_oe_out, sda_oe_out} <= 2'h0;
      {bus_irq_out, timer_irq_out} <= 2'h0;
      timer_prio_out <= 2'h0;
    end
    else
    begin
      sfr_rdata_out  <= rdata_nxt;
      scl_out        <= 1'b0; // open drain: only ever drives low
      sda_out        <= 1'b0;
      scl_oe_out     <= scl_oe_nxt;
      sda_oe_out     <= sda_oe_nxt;
      bus_irq_out    <= bus_irq_nxt;
      timer_irq_out  <= timer_irq_nxt;
      timer_prio_out <= {timer_prio_high_bit_in, timer_prio_low_bit_in}; // R21
    end
  end

endmodule
